// [rtl/tpoa_pkg.sv]
// Purpose: Constants and types for the time-proportional output assignment block
// Assumes: 40 MHz mclk, byte addressed Avalon-MM register window
// Notes:   Percent values are held in tenths of a percent (0 to 1000)
package tpoa_pkg;
  // Register byte offsets
  localparam logic [5:0] OFS_CTRL    = 6'h00;
  localparam logic [5:0] OFS_ASSIGN0 = 6'h04;
  localparam logic [5:0] OFS_PERIOD0 = 6'h14;
  localparam logic [5:0] OFS_MINW    = 6'h24;
  localparam logic [5:0] OFS_STATUS  = 6'h28;
  localparam logic [5:0] OFS_MASK    = 6'h2C;
  localparam logic [5:0] OFS_OUTS    = 6'h30;
  // Control fields
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_ONOFF_BIT = 1;
  // Status fields: bits 3..0 period start per output, bit 4 rejected write
  localparam int STAT_REJECT_BIT = 4;
  localparam int STAT_W          = 5;
  // Assignment codes and defaults
  localparam logic [7:0] ASSIGN_MAX  = 8'h90;
  localparam logic [7:0] DEF_A1_FOUR = 8'h2F;
  localparam logic [7:0] DEF_A2_FOUR = 8'h4F;
  localparam logic [7:0] DEF_A3_FOUR = 8'h6F;
  localparam logic [7:0] DEF_A4_FOUR = 8'h8F;
  localparam logic [7:0] DEF_A3_TWO  = 8'h20;
  localparam logic [7:0] DEF_A4_TWO  = 8'h40;
  // Period and width settings
  localparam logic [6:0] PERIOD_MAX = 7'h63;
  localparam logic [6:0] PERIOD_DEF = 7'h02;
  localparam logic [9:0] MINW_MAX   = 10'h1F4;
  localparam logic [9:0] MINW_DEF   = 10'h00A;
  localparam logic [9:0] FULL_SCALE = 10'h3E8;
  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int RES_MS         = 2;
  localparam int RES_CYCLES     = RES_MS * 1000000 / CLK_PERIOD_NS;
  localparam int ZERO_PERIOD_MS = 500;
  localparam logic [15:0] ZERO_PERIOD_TICKS = 16'(ZERO_PERIOD_MS / RES_MS);
  localparam logic [15:0] TICKS_PER_S       = 16'(1000 / RES_MS);
  // Global source codes
  localparam logic [7:0] SRC_CTRL_ERR   = 8'h01;
  localparam logic [7:0] SRC_ALL_AL_OR  = 8'h02;
  localparam logic [7:0] SRC_ALL_AL_AND = 8'h03;
  localparam logic [7:0] SRC_AL13_OR    = 8'h04;
  localparam logic [7:0] SRC_AL13_AND   = 8'h05;
  localparam logic [7:0] SRC_IN_ERR_OR  = 8'h06;
  localparam logic [7:0] SRC_RSP_ERR_OR = 8'h07;
  localparam logic [7:0] SRC_HB_OR      = 8'h08;
  localparam logic [7:0] SRC_HS_OR      = 8'h09;
  localparam logic [7:0] SRC_OC_OR      = 8'h0A;
  // Per-channel selectors, channel n uses codes 32*n .. 32*n+31
  localparam logic [4:0] SEL_AL1       = 5'h00;
  localparam logic [4:0] SEL_AL2       = 5'h01;
  localparam logic [4:0] SEL_AL3       = 5'h02;
  localparam logic [4:0] SEL_ALL_OR    = 5'h03;
  localparam logic [4:0] SEL_ALL_AND   = 5'h04;
  localparam logic [4:0] SEL_IN_ERR    = 5'h05;
  localparam logic [4:0] SEL_RSP_ERR   = 5'h06;
  localparam logic [4:0] SEL_HB        = 5'h07;
  localparam logic [4:0] SEL_HS        = 5'h08;
  localparam logic [4:0] SEL_OC        = 5'h09;
  localparam logic [4:0] SEL_PV        = 5'h0A;
  localparam logic [4:0] SEL_ISP       = 5'h0B;
  localparam logic [4:0] SEL_LSP       = 5'h0C;
  localparam logic [4:0] SEL_RSP       = 5'h0D;
  localparam logic [4:0] SEL_CTRL_HEAT = 5'h0F;
  localparam logic [4:0] SEL_CTRL_COOL = 5'h10;
  localparam logic [4:0] SEL_TR_HEAT   = 5'h11;
  localparam logic [4:0] SEL_TR_COOL   = 5'h12;

  typedef struct packed {
    logic       is_ctrl;
    logic       is_analog;
    logic       bit_on;
    logic [9:0] val;
  } tpoa_src_s;
endpackage

// [rtl/tpoa_top.sv]
// Purpose: Source routing and time-proportional drive of four outputs
// Assumes: Channel values arrive in tenths of a percent, synchronous to mclk
// Notes:   Register window on Avalon-MM, one level interrupt
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module tpoa_top
  import tpoa_pkg::*;
#(
  parameter int TICK_CYCLES = RES_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        four_chan_variant,
  input  wire logic        linear_variant,
  input  wire logic [15:0] device_status,
  input  wire logic [11:0] ch_alarm,
  input  wire logic [3:0]  ch_input_err,
  input  wire logic [3:0]  ch_rsp_err,
  input  wire logic [3:0]  ch_heater_burnout_alarm,
  input  wire logic [3:0]  ch_heater_short_alarm,
  input  wire logic [3:0]  ch_heater_overcurrent_alarm,
  input  wire logic [39:0] ch_process_value,
  input  wire logic [39:0] ch_internal_setpoint,
  input  wire logic [39:0] ch_local_setpoint,
  input  wire logic [39:0] ch_remote_setpoint,
  input  wire logic [39:0] ch_manipulated_value_heat,
  input  wire logic [39:0] ch_manipulated_value_cool,
  output logic             output_one,
  output logic             output_two,
  output logic             output_three,
  output logic             output_four,
  output logic      [9:0]  lin_level_one,
  output logic      [9:0]  lin_level_two
);

  logic [1:0]        ctrl_r;
  logic [7:0]        assign_r [4];
  logic [6:0]        period_r [4];
  logic [9:0]        minw_r;
  logic [STAT_W-1:0] status_r;
  logic [STAT_W-1:0] mask_r;
  logic              rd_ack_r;
  logic [16:0]       tick_cnt_r;
  logic              tick;
  logic [15:0]       cnt_r     [4];
  logic [15:0]       per_len_r [4];
  logic [15:0]       on_len_r  [4];
  logic [15:0]       per_nxt   [4];
  logic [15:0]       on_nxt    [4];
  tpoa_src_s         src       [4];
  logic [3:0]        start_ev;
  logic [3:0]        out_r;
  logic [9:0]        lin_r     [2];
  logic              cfg_wr;
  logic              wr_reject;
  logic [3:0]        chan_ok;
  logic [3:0]        ch_all_or;
  logic [3:0]        ch_al13_or;
  logic [3:0]        ch_al13_and;
  wire  logic        run = ctrl_r[CTRL_RUN_BIT];
  wire  logic        onoff_method = ctrl_r[CTRL_ONOFF_BIT];

  // Control period in 2 ms ticks
  function automatic logic [15:0] per_ticks(input logic [6:0] s);
    per_ticks = (s == 7'h00) ? ZERO_PERIOD_TICKS : 16'(s * TICKS_PER_S);
  endfunction

  // Per-channel condition summaries
  always_comb begin
    chan_ok = four_chan_variant ? 4'hF : 4'h3;
    for (int c = 0; c < 4; c++) begin
      ch_al13_or[c]  = |ch_alarm[3*c +: 3];
      ch_al13_and[c] = &ch_alarm[3*c +: 3];
      ch_all_or[c]   = ch_al13_or[c] | ch_heater_burnout_alarm[c] | ch_heater_short_alarm[c]
                       | ch_heater_overcurrent_alarm[c];
    end
  end

  // Evaluate one assignment code into a source value
  function automatic tpoa_src_s src_eval(input logic [7:0] code);
    tpoa_src_s  s;
    logic [1:0] ch;
    logic [4:0] sel;
    s   = '0;
    ch  = 2'(code[7:5] - 3'h1);
    sel = code[4:0];
    if (code < 8'h20) begin
      unique case (code)
        SRC_CTRL_ERR:   s.bit_on = |device_status[13:0];
        SRC_ALL_AL_OR:  s.bit_on = |(ch_all_or & chan_ok);
        SRC_ALL_AL_AND: s.bit_on = &(ch_all_or | ~chan_ok);
        SRC_AL13_OR:    s.bit_on = |(ch_al13_or & chan_ok);
        SRC_AL13_AND:   s.bit_on = &(ch_al13_and | ~chan_ok);
        SRC_IN_ERR_OR:  s.bit_on = |(ch_input_err & chan_ok);
        SRC_RSP_ERR_OR: s.bit_on = |(ch_rsp_err & chan_ok);
        SRC_HB_OR:      s.bit_on = |(ch_heater_burnout_alarm & chan_ok);
        SRC_HS_OR:      s.bit_on = |(ch_heater_short_alarm & chan_ok);
        SRC_OC_OR:      s.bit_on = |(ch_heater_overcurrent_alarm & chan_ok);
        default:        s.bit_on = 1'b0;
      endcase
    end else if (chan_ok[ch]) begin
      unique case (sel)
        SEL_AL1:       s.bit_on = ch_alarm[3*ch];
        SEL_AL2:       s.bit_on = ch_alarm[3*ch+1];
        SEL_AL3:       s.bit_on = ch_alarm[3*ch+2];
        SEL_ALL_OR:    s.bit_on = ch_all_or[ch];
        SEL_ALL_AND:   s.bit_on = ch_al13_and[ch];
        SEL_IN_ERR:    s.bit_on = ch_input_err[ch];
        SEL_RSP_ERR:   s.bit_on = ch_rsp_err[ch];
        SEL_HB:        s.bit_on = ch_heater_burnout_alarm[ch];
        SEL_HS:        s.bit_on = ch_heater_short_alarm[ch];
        SEL_OC:        s.bit_on = ch_heater_overcurrent_alarm[ch];
        SEL_PV:        s = '{1'b0, 1'b1, 1'b0, ch_process_value[10*ch +: 10]};
        SEL_ISP:       s = '{1'b0, 1'b1, 1'b0, ch_internal_setpoint[10*ch +: 10]};
        SEL_LSP:       s = '{1'b0, 1'b1, 1'b0, ch_local_setpoint[10*ch +: 10]};
        SEL_RSP:       s = '{1'b0, 1'b1, 1'b0, ch_remote_setpoint[10*ch +: 10]};
        SEL_CTRL_HEAT: s = '{1'b1, 1'b1, 1'b0, ch_manipulated_value_heat[10*ch +: 10]};
        SEL_CTRL_COOL: s = '{1'b1, 1'b1, 1'b0, ch_manipulated_value_cool[10*ch +: 10]};
        SEL_TR_HEAT:   s = '{1'b1, 1'b1, 1'b0, ch_manipulated_value_heat[10*ch +: 10]};
        SEL_TR_COOL:   s = '{1'b1, 1'b1, 1'b0, ch_manipulated_value_cool[10*ch +: 10]};
        default:       s = '0;
      endcase
    end
    return s;
  endfunction

  // Register write decode
  always_comb begin
    cfg_wr    = avs_write && (avs_address >= OFS_ASSIGN0) && (avs_address <= OFS_MINW);
    wr_reject = cfg_wr && run;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= 2'h0;
    end else if (avs_write && avs_address == OFS_CTRL) begin
      ctrl_r <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      assign_r[0] <= four_chan_variant ? DEF_A1_FOUR : 8'h00;
      assign_r[1] <= four_chan_variant ? DEF_A2_FOUR : 8'h00;
      assign_r[2] <= four_chan_variant ? DEF_A3_FOUR : DEF_A3_TWO;
      assign_r[3] <= four_chan_variant ? DEF_A4_FOUR : DEF_A4_TWO;
      for (int k = 0; k < 4; k++) begin
        period_r[k] <= PERIOD_DEF;
      end
      minw_r <= MINW_DEF;
    end else if (cfg_wr && !run) begin
      for (int k = 0; k < 4; k++) begin
        if (avs_address == OFS_ASSIGN0 + 6'(4*k) && avs_writedata[7:0] <= ASSIGN_MAX) begin
          assign_r[k] <= avs_writedata[7:0];
        end
        if (avs_address == OFS_PERIOD0 + 6'(4*k) && avs_writedata[6:0] <= PERIOD_MAX
            && avs_writedata[31:7] == 25'h0) begin
          period_r[k] <= avs_writedata[6:0];
        end
      end
      if (avs_address == OFS_MINW && avs_writedata[9:0] <= MINW_MAX && avs_writedata[31:10] == 22'h0) begin
        minw_r <= avs_writedata[9:0];
      end
    end
  end

  // Read path: one wait state, status cleared as its value is captured
  assign avs_waitrequest = avs_read && !rd_ack_r;

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_ack_r     <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_ack_r <= avs_read && !rd_ack_r;
      if (avs_read && !rd_ack_r) begin
        unique case (avs_address)
          OFS_CTRL:                   avs_readdata <= {30'h0, ctrl_r};
          OFS_ASSIGN0:                avs_readdata <= {24'h0, assign_r[0]};
          OFS_ASSIGN0 + 6'h04:        avs_readdata <= {24'h0, assign_r[1]};
          OFS_ASSIGN0 + 6'h08:        avs_readdata <= {24'h0, assign_r[2]};
          OFS_ASSIGN0 + 6'h0C:        avs_readdata <= {24'h0, assign_r[3]};
          OFS_PERIOD0:                avs_readdata <= {25'h0, period_r[0]};
          OFS_PERIOD0 + 6'h04:        avs_readdata <= {25'h0, period_r[1]};
          OFS_PERIOD0 + 6'h08:        avs_readdata <= {25'h0, period_r[2]};
          OFS_PERIOD0 + 6'h0C:        avs_readdata <= {25'h0, period_r[3]};
          OFS_MINW:                   avs_readdata <= {22'h0, minw_r};
          OFS_STATUS:                 avs_readdata <= {27'h0, status_r};
          OFS_MASK:                   avs_readdata <= {27'h0, mask_r};
          OFS_OUTS:                   avs_readdata <= {28'h0, out_r};
          default:                    avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Sticky events, read clears, new events win
  always_ff @(posedge mclk) begin
    if (reset) begin
      status_r <= '0;
    end else begin
      status_r <= ((avs_read && !rd_ack_r && avs_address == OFS_STATUS) ? '0 : status_r)
                  | {wr_reject, start_ev};
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      mask_r <= '0;
    end else if (avs_write && avs_address == OFS_MASK) begin
      mask_r <= avs_writedata[STAT_W-1:0];
    end
  end

  assign irq = |(status_r & mask_r);

  // 2 ms timebase
  always_ff @(posedge mclk) begin
    if (reset || tick) begin
      tick_cnt_r <= 17'h0_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 17'h0_0001;
    end
  end

  assign tick = (tick_cnt_r == 17'(TICK_CYCLES - 1));

  // Per-output time-proportional drive
  for (genvar i = 0; i < 4; i++) begin : g_out
    logic [25:0] prod;
    logic [15:0] on_calc;
    always_comb begin
      src[i]     = src_eval(assign_r[i]);
      per_nxt[i] = per_ticks(period_r[i]);
      prod       = per_nxt[i] * src[i].val;
      on_calc    = 16'(prod / 26'd1000);
      if (src[i].val == 10'h000 || src[i].val < minw_r) begin
        on_nxt[i] = 16'h0000;
      end else if (src[i].val >= FULL_SCALE - minw_r) begin
        on_nxt[i] = per_nxt[i];
      end else if (on_calc == 16'h0000) begin
        on_nxt[i] = 16'h0001;
      end else if (on_calc >= per_nxt[i]) begin
        on_nxt[i] = per_nxt[i] - 16'h0001;
      end else begin
        on_nxt[i] = on_calc;
      end
    end

    assign start_ev[i] = tick && (cnt_r[i] + 16'h0001 >= per_len_r[i]);

    always_ff @(posedge mclk) begin
      if (reset) begin
        cnt_r[i]     <= 16'h0000;
        per_len_r[i] <= 16'h0000;
        on_len_r[i]  <= 16'h0000;
      end else if (start_ev[i]) begin
        cnt_r[i]     <= 16'h0000;
        per_len_r[i] <= per_nxt[i];
        on_len_r[i]  <= on_nxt[i];
      end else if (tick) begin
        cnt_r[i] <= cnt_r[i] + 16'h0001;
      end
    end

    always_ff @(posedge mclk) begin
      if (reset) begin
        out_r[i] <= 1'b0;
      end else if (linear_variant && i < 2) begin
        out_r[i] <= 1'b0;
      end else if (src[i].is_ctrl) begin
        out_r[i] <= cnt_r[i] < on_len_r[i];
      end else begin
        out_r[i] <= src[i].bit_on && !src[i].is_analog;
      end
    end
  end

  // Linear levels for outputs one and two
  for (genvar j = 0; j < 2; j++) begin : g_lin
    always_ff @(posedge mclk) begin
      if (reset || !linear_variant) begin
        lin_r[j] <= 10'h000;
      end else if (!src[j].is_analog) begin
        lin_r[j] <= src[j].bit_on ? FULL_SCALE : 10'h000;
      end else if (src[j].is_ctrl && onoff_method) begin
        lin_r[j] <= (src[j].val != 10'h000) ? FULL_SCALE : 10'h000;
      end else begin
        lin_r[j] <= src[j].val;
      end
    end
  end

  assign output_one    = out_r[0];
  assign output_two    = out_r[1];
  assign output_three  = out_r[2];
  assign output_four   = out_r[3];
  assign lin_level_one = lin_r[0];
  assign lin_level_two = lin_r[1];

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_ctrl_err_map: assert property (
    (assign_r[1] == SRC_CTRL_ERR && !linear_variant)
      |=> output_two == |$past(device_status[13:0]))
    else $error("controller error source does not follow status bits");
  chk_run_lock: assert property (
    run && avs_write |=> $stable(assign_r[0]) && $stable(period_r[0]) && $stable(minw_r))
    else $error("configuration changed while running");
  chk_code_range: assert property (assign_r[1] <= ASSIGN_MAX && assign_r[3] <= ASSIGN_MAX)
    else $error("assignment code out of range");
  chk_period_len: assert property (
    start_ev[2] |=> per_len_r[2] == (($past(period_r[2]) == 7'h00) ? 16'd250 : 16'($past(period_r[2]) * 500)))
    else $error("period length wrong");
  chk_min_off: assert property (
    start_ev[2] && src[2].is_ctrl && src[2].val < minw_r |=> on_len_r[2] == 16'h0000 ##1 !output_three [*3])
    else $error("value below minimum width not held off");
  chk_full_on: assert property (
    start_ev[2] && src[2].is_ctrl && src[2].val >= FULL_SCALE - minw_r |=> on_len_r[2] == per_len_r[2])
    else $error("value above full minus width not held on");
  chk_min_tick: assert property (
    start_ev[2] && src[2].val != 10'h000 && src[2].val >= minw_r && src[2].val < FULL_SCALE - minw_r
      |=> on_len_r[2] >= 16'h0001 && on_len_r[2] < per_len_r[2])
    else $error("ON or OFF time shorter than one tick");
  chk_latch_hold: assert property (!start_ev[3] |=> $stable(on_len_r[3]) && $stable(per_len_r[3]))
    else $error("latched duration changed mid period");
  chk_lin_full: assert property (
    linear_variant && !src[0].is_analog |=> lin_level_one == FULL_SCALE || lin_level_one == 10'h000)
    else $error("linear on/off level not full or zero");
  chk_reject_sticky: assert property (
    wr_reject || (status_r[STAT_REJECT_BIT] && !(avs_read && avs_address == OFS_STATUS))
      |=> status_r[STAT_REJECT_BIT])
    else $error("rejected write flag not held until status read");

  cov_period_start: cover property (start_ev[0] && on_len_r[0] != 16'h0000);
  cov_status_read: cover property (avs_read && avs_address == OFS_STATUS && status_r != '0);
  cov_reject: cover property (wr_reject);

endmodule // tpoa_top

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the output assignment and pulse drive block
// Assumes: Avalon-MM master in the bench, short tick of 4 mclk cycles
// Notes:   Pulse ON time is measured over one whole control period
`timescale 1ns/100ps
module tb_top;
  import tpoa_pkg::*;
  localparam int TICK = 4;
  logic        mclk, reset, avs_read, avs_write, four_chan, linear, irq, avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] dev_status;
  logic [11:0] alarm;
  logic [39:0] mv_heat, pv, rsp_val, mv_cool;
  logic [9:0]  lin_one, lin_two;
  logic [3:0]  outs, in_err, hb_alarm;
  int          mismatches, n_compared, c;

  tpoa_top #(.TICK_CYCLES(TICK)) uut (
    .mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .four_chan_variant(four_chan), .linear_variant(linear), .device_status(dev_status), .ch_alarm(alarm),
    .ch_input_err(in_err), .ch_rsp_err(4'h0), .ch_heater_burnout_alarm(hb_alarm), .ch_heater_short_alarm(4'h0),
    .ch_heater_overcurrent_alarm(4'h0), .ch_process_value(pv),
    .ch_internal_setpoint(40'h00_0000_0000), .ch_local_setpoint(40'h00_0000_0000),
    .ch_remote_setpoint(rsp_val), .ch_manipulated_value_heat(mv_heat),
    .ch_manipulated_value_cool(mv_cool), .output_one(outs[0]), .output_two(outs[1]),
    .output_three(outs[2]), .output_four(outs[3]), .lin_level_one(lin_one), .lin_level_two(lin_two));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge mclk);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 50);
    if (t >= 50) chk(32'h0000_0001, 32'h0000_0000, "bus timeout");
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic rdchk(input logic [5:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask

  task automatic do_reset(input logic four);
    four_chan <= four;
    reset     <= 1'b1;
    repeat (3) @(posedge mclk);
    reset     <= 1'b0;
  endtask

  // Measures ON cycles of output_three over one full zero-setting period
  task automatic pulse(input logic [9:0] mv, input logic [9:0] minw, input int exp_ticks);
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b1, OFS_MINW, {22'h00_0000, minw});
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    mv_heat[9:0] <= mv;
    // Outlast a default-length period still running, then one new period
    repeat ((int'(PERIOD_DEF) * int'(TICKS_PER_S) + int'(ZERO_PERIOD_TICKS)) * TICK + 100) @(posedge mclk);
    c = 0;
    repeat (int'(ZERO_PERIOD_TICKS) * TICK) begin
      @(posedge mclk);
      c += outs[2];
    end
    chk(c, exp_ticks * TICK, "pulse on cycles");
  endtask

  task automatic summarize();
    $display("mismatches %0d, comparisons %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    mismatches++;
    summarize();
  end

  initial begin
    mismatches = 0;
    n_compared = 0;
    {avs_read, avs_write, avs_address, avs_writedata} = '0;
    {linear, dev_status, alarm, mv_heat} = '0;
    {in_err, hb_alarm, pv, rsp_val, mv_cool} = '0;
    reset = 1'b1;
    four_chan = 1'b1;
    do_reset(1'b1);
    rdchk(OFS_ASSIGN0, {24'h00_0000, DEF_A1_FOUR}, "assign1 default");
    rdchk(6'h08, {24'h00_0000, DEF_A2_FOUR}, "assign2 default");
    rdchk(6'h0C, {24'h00_0000, DEF_A3_FOUR}, "assign3 default");
    rdchk(6'h10, {24'h00_0000, DEF_A4_FOUR}, "assign4 default");
    rdchk(6'h20, {25'h000_0000, PERIOD_DEF}, "period4 default");
    rdchk(OFS_MINW, {22'h00_0000, MINW_DEF}, "width default");
    rdchk(6'h3C, 32'h0000_0000, "unmapped read");
    bus(1'b1, OFS_ASSIGN0, 32'h0000_0091);
    rdchk(OFS_ASSIGN0, {24'h00_0000, DEF_A1_FOUR}, "code 145 ignored");
    bus(1'b1, OFS_ASSIGN0, {24'h00_0000, ASSIGN_MAX});
    rdchk(OFS_ASSIGN0, {24'h00_0000, ASSIGN_MAX}, "code 144 taken");
    bus(1'b1, OFS_PERIOD0, 32'h0000_0064);
    rdchk(OFS_PERIOD0, {25'h000_0000, PERIOD_DEF}, "period 100 ignored");
    bus(1'b1, OFS_PERIOD0, {25'h000_0000, PERIOD_MAX});
    rdchk(OFS_PERIOD0, {25'h000_0000, PERIOD_MAX}, "period 99 taken");
    bus(1'b1, OFS_MINW, 32'h0000_01F5);
    rdchk(OFS_MINW, {22'h00_0000, MINW_DEF}, "width 50.1 ignored");
    bus(1'b1, 6'h20, 32'h0000_0014);
    rdchk(6'h20, 32'h0000_0014, "relay period 20 s");
    // Same controller-error code on two outputs
    bus(1'b1, OFS_ASSIGN0, {24'h00_0000, SRC_CTRL_ERR});
    bus(1'b1, 6'h08, {24'h00_0000, SRC_CTRL_ERR});
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    dev_status <= 16'h4000;
    repeat (4) @(posedge mclk);
    chk(outs[1:0], 2'b00, "bit 14 alone");
    dev_status <= 16'h2000;
    repeat (4) @(posedge mclk);
    chk(outs[1:0], 2'b11, "bit 13 on both");
    rdchk(OFS_OUTS, 32'h0000_0003, "outputs register");
    dev_status <= 16'h0000;
    // Write while running is ignored and flagged
    bus(1'b1, OFS_MASK, 32'h0000_0001 << STAT_REJECT_BIT);
    chk(irq, 1'b0, "irq before reject");
    bus(1'b1, OFS_ASSIGN0, 32'h0000_0000);
    rdchk(OFS_ASSIGN0, {24'h00_0000, SRC_CTRL_ERR}, "assign while running");
    @(posedge mclk);
    chk(irq, 1'b1, "irq on reject");
    bus(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd[STAT_REJECT_BIT], 1'b1, "reject status bit");
    @(posedge mclk);
    chk(irq, 1'b0, "irq after status read");
    rdchk(OFS_MASK, 32'h0000_0001 << STAT_REJECT_BIT, "mask readback");
    // Pulse drive on output_three from channel 1 control heat
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b1, 6'h0C, 32'h0000_002F);
    bus(1'b1, 6'h1C, 32'h0000_0000);
    pulse(10'h1F4, MINW_DEF, 125);
    pulse(10'h005, MINW_DEF, 0);
    pulse(10'h3E3, MINW_DEF, int'(ZERO_PERIOD_TICKS));
    pulse(10'h002, 10'h000, 1);
    // Linear outputs
    linear <= 1'b1;
    mv_heat[9:0] <= 10'h12C;
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b1, OFS_ASSIGN0, 32'h0000_002F);
    bus(1'b1, 6'h08, {24'h00_0000, SRC_CTRL_ERR});
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (4) @(posedge mclk);
    chk(lin_one, 10'h12C, "linear value");
    chk(lin_two, 10'h000, "linear on/off false");
    bus(1'b1, OFS_CTRL, 32'h0000_0003);
    dev_status <= 16'h0001;
    repeat (4) @(posedge mclk);
    chk(lin_one, FULL_SCALE, "on/off control full");
    chk(lin_two, FULL_SCALE, "linear on/off true");
    // Analog sources pass, transfer values follow on/off control
    pv[9:0]      <= 10'h1F4;
    rsp_val[9:0] <= 10'h0C8;
    mv_cool[9:0] <= 10'h064;
    bus(1'b1, OFS_CTRL, 32'h0000_0002);
    bus(1'b1, OFS_ASSIGN0, 32'h0000_002A);
    bus(1'b1, 6'h08, 32'h0000_0032);
    repeat (4) @(posedge mclk);
    chk(lin_one, 10'h1F4, "process value passes");
    chk(lin_two, FULL_SCALE, "transfer under on/off");
    bus(1'b1, 6'h08, 32'h0000_002D);
    repeat (4) @(posedge mclk);
    chk(lin_two, 10'h0C8, "remote setpoint passes");
    linear <= 1'b0;
    dev_status <= 16'h0000;
    // Two-channel variant
    do_reset(1'b0);
    rdchk(6'h0C, {24'h00_0000, DEF_A3_TWO}, "assign3 two-chan");
    rdchk(6'h10, {24'h00_0000, DEF_A4_TWO}, "assign4 two-chan");
    bus(1'b1, 6'h0C, 32'h0000_0060);
    bus(1'b1, 6'h10, 32'h0000_0040);
    bus(1'b1, OFS_CTRL, 32'h0000_0001);
    alarm <= 12'h048;
    repeat (4) @(posedge mclk);
    chk(outs[3:2], 2'b10, "channel 3 absent, channel 2 present");
    // Global OR sources skip channels three and four
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    bus(1'b1, 6'h0C, {24'h00_0000, SRC_IN_ERR_OR});
    bus(1'b1, 6'h10, {24'h00_0000, SRC_HB_OR});
    in_err   <= 4'h4;
    hb_alarm <= 4'h8;
    repeat (4) @(posedge mclk);
    chk(outs[3:2], 2'b00, "channel 3, 4 errors ignored");
    in_err   <= 4'h2;
    hb_alarm <= 4'h1;
    repeat (4) @(posedge mclk);
    chk(outs[3:2], 2'b11, "channel 1, 2 errors seen");
    summarize();
  end
endmodule // tb_top
